// file: aacr_regs.vh
`ifndef AACR_REGS_VH
`define AACR_REGS_VH
// register byte offsets
`define AACR_DMA_ADDR_BASE 12'h08C
`define AACR_APP_CTRL_OFS 12'h100
`define AACR_CAP_CTRL_BASE 12'h104
`define AACR_APP_STAT_OFS 12'h160
`define AACR_UNIT_STRIDE 12'h010
// reset values
`define AACR_DMA_ADDR_RST 32'h0000_0000
`define AACR_APP_CTRL_RST 32'h0000_0000
`define AACR_CAP_CTRL_RST 32'h0000_0000
// application control fields
`define AACR_LED_USER_HI 15
`define AACR_LED_USER_LO 12
`define AACR_LED_MODE_BIT 8
`define AACR_UNIT_EN_HI 3
`define AACR_UNIT_EN_LO 0
// capture unit control fields
`define AACR_BYTE_ORDER_BIT 16
`define AACR_POL_HI 15
`define AACR_POL_LO 12
`define AACR_SRC_HI 11
`define AACR_SRC_LO 8
// application status fields
`define AACR_ERR_HI 15
`define AACR_ERR_LO 12
// trigger and led mode codes
`define AACR_SRC_FIRST 4'h1
`define AACR_SRC_LAST 4'hC
`define AACR_POL_FALL 4'h1
`define AACR_LED_MODE_USER 1'b1
// trigger re-arm holdoff after a config change, in cycles
`define AACR_TRIG_HOLDOFF 2'h3
`endif

// file: aacr_trig.v
`timescale 1ns/10ps
`default_nettype none
`include "aacr_regs.vh"
module aacr_trig #(
	parameter NUM_SRC = 12
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// trigger lines and selection
	input wire [NUM_SRC-1:0] trig_lines,
	input wire [3:0] trigger_source_select,
	input wire [3:0] trigger_edge_polarity,
	// result
	output reg trig_pulse
);
	wire src_valid;
	wire sel_raw;
	reg sync_a;
	reg sync_b;
	reg hist;
	reg [7:0] cfg_q;
	reg [1:0] holdoff;
	wire edge_hit;
	wire [3:0] src_idx;

	assign src_valid = (trigger_source_select >= `AACR_SRC_FIRST) &&
		(trigger_source_select <= `AACR_SRC_LAST);
	assign src_idx = trigger_source_select - `AACR_SRC_FIRST;
	assign sel_raw = src_valid ? trig_lines[src_idx] : 1'b0;
	assign edge_hit = (trigger_edge_polarity == `AACR_POL_FALL) ? (~sync_b & hist) : (sync_b & ~hist);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			hist <= 1'b0;
			cfg_q <= 8'h00;
			holdoff <= `AACR_TRIG_HOLDOFF;
			trig_pulse <= 1'b0;
		end else begin
			sync_a <= sel_raw;
			sync_b <= sync_a;
			hist <= sync_b;
			cfg_q <= {trigger_source_select, trigger_edge_polarity};
			// suppress false edges while the new selection settles
			if (cfg_q != {trigger_source_select, trigger_edge_polarity}) begin
				holdoff <= `AACR_TRIG_HOLDOFF;
			end else if (holdoff != 2'h0) begin
				holdoff <= holdoff - 2'h1;
			end
			trig_pulse <= src_valid && (holdoff == 2'h0) && edge_hit;
		end
	end
endmodule // aacr_trig
`default_nettype wire

// file: aacr_endian.v
`timescale 1ns/10ps
`default_nettype none
module aacr_endian #(
	parameter WIDTH = 32
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// converter side
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	input wire swap,
	// dma side
	output reg [WIDTH-1:0] out_data,
	output reg out_valid
);
	localparam NBYTES = WIDTH / 8;
	wire [WIDTH-1:0] swapped;
	genvar b;

	generate
		for (b = 0; b < NBYTES; b = b + 1) begin : g_byte
			assign swapped[8*b +: 8] = in_data[8*(NBYTES-1-b) +: 8];
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_data <= swap ? swapped : in_data;
			end
		end
	end
endmodule // aacr_endian
`default_nettype wire

// file: aacr_top.v
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "aacr_regs.vh"
module aacr_top #(
	parameter ADDR_W = 12,
	parameter NUM_UNITS = 4,
	parameter DATA_W = 32
) (
	// apb clock, reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	// trigger inputs and pulses
	input wire [3:0] rear_trigger,
	input wire [7:0] backplane_trigger,
	output wire [NUM_UNITS-1:0] trigger_pulse,
	// front leds
	input wire [3:0] board_status_led,
	output reg [3:0] front_led,
	// capture units
	output wire [NUM_UNITS-1:0] capture_unit_enable,
	input wire [NUM_UNITS-1:0] capture_unit_error_event,
	output reg [NUM_UNITS-1:0] capture_unit_error,
	// dma address tracking
	input wire [NUM_UNITS-1:0] dma_addr_load,
	input wire [32*NUM_UNITS-1:0] dma_addr_value,
	output wire [32*NUM_UNITS-1:0] dma_next_write_address,
	// converter to dma data path
	input wire [DATA_W*NUM_UNITS-1:0] adc_data,
	input wire [NUM_UNITS-1:0] adc_valid,
	output wire [DATA_W*NUM_UNITS-1:0] dma_data,
	output wire [NUM_UNITS-1:0] dma_valid
);
	wire [11:0] trig_lines;
	wire setup_phase;
	wire wr_access;
	wire hit_app_ctrl;
	wire hit_app_stat;
	wire [NUM_UNITS-1:0] hit_dma;
	wire [NUM_UNITS-1:0] hit_cap;
	wire [32*NUM_UNITS-1:0] unit_rd;
	wire [11:0] addr12;
	reg [3:0] user_led_pattern;
	reg led_mode_select;
	reg [NUM_UNITS-1:0] unit_en;
	reg [31:0] next_rd;
	reg next_hit;
	integer i;
	genvar g;
	localparam [31:0] APP_RST = `AACR_APP_CTRL_RST;
	localparam [31:0] CAP_RST = `AACR_CAP_CTRL_RST;

	assign addr12 = paddr[11:0];
	assign trig_lines = {backplane_trigger, rear_trigger};
	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign pready = 1'b1;
	assign hit_app_ctrl = (addr12 == `AACR_APP_CTRL_OFS);
	assign hit_app_stat = (addr12 == `AACR_APP_STAT_OFS);
	assign capture_unit_enable = unit_en;

	// application control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_led_pattern <= APP_RST[`AACR_LED_USER_HI:`AACR_LED_USER_LO];
			led_mode_select <= APP_RST[`AACR_LED_MODE_BIT];
			unit_en <= APP_RST[`AACR_UNIT_EN_HI:`AACR_UNIT_EN_LO];
		end else if (wr_access && hit_app_ctrl) begin
			user_led_pattern <= pwdata[`AACR_LED_USER_HI:`AACR_LED_USER_LO];
			led_mode_select <= pwdata[`AACR_LED_MODE_BIT];
			unit_en <= pwdata[`AACR_UNIT_EN_HI:`AACR_UNIT_EN_LO];
		end
	end

	// front led output
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			front_led <= 4'h0;
		end else if (led_mode_select == `AACR_LED_MODE_USER) begin
			front_led <= user_led_pattern;
		end else begin
			front_led <= board_status_led;
		end
	end

	// per unit registers and logic
	generate
		for (g = 0; g < NUM_UNITS; g = g + 1) begin : g_unit
			localparam integer GI = g;
			localparam [11:0] G12 = GI[11:0];
			localparam [11:0] DMA_OFS = `AACR_DMA_ADDR_BASE + G12 * `AACR_UNIT_STRIDE;
			localparam [11:0] CAP_OFS = `AACR_CAP_CTRL_BASE + G12 * `AACR_UNIT_STRIDE;
			reg [31:0] dma_addr;
			reg byte_order;
			reg [3:0] edge_pol;
			reg [3:0] src_sel;

			assign hit_dma[g] = (addr12 == DMA_OFS);
			assign hit_cap[g] = (addr12 == CAP_OFS);
			assign dma_next_write_address[32*g +: 32] = dma_addr;

			// next write address, hardware update wins
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dma_addr <= `AACR_DMA_ADDR_RST;
				end else if (dma_addr_load[g]) begin
					dma_addr <= dma_addr_value[32*g +: 32];
				end else if (wr_access && hit_dma[g]) begin
					dma_addr <= pwdata;
				end
			end

			// capture unit control
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					byte_order <= CAP_RST[`AACR_BYTE_ORDER_BIT];
					edge_pol <= CAP_RST[`AACR_POL_HI:`AACR_POL_LO];
					src_sel <= CAP_RST[`AACR_SRC_HI:`AACR_SRC_LO];
				end else if (wr_access && hit_cap[g]) begin
					byte_order <= pwdata[`AACR_BYTE_ORDER_BIT];
					edge_pol <= pwdata[`AACR_POL_HI:`AACR_POL_LO];
					src_sel <= pwdata[`AACR_SRC_HI:`AACR_SRC_LO];
				end
			end

			// sticky error, held clear while disabled
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					capture_unit_error[g] <= 1'b0;
				end else if (!unit_en[g]) begin
					capture_unit_error[g] <= 1'b0;
				end else if (capture_unit_error_event[g]) begin
					capture_unit_error[g] <= 1'b1;
				end
			end

			// read view, reserved bits zero
			assign unit_rd[32*g +: 32] = hit_dma[g] ? dma_addr :
				hit_cap[g] ? {15'h0000, byte_order, edge_pol, src_sel, 8'h00} : 32'h0000_0000;

			aacr_trig #(
				.NUM_SRC(12)
			) u_trig (
				.pclk(pclk),
				.presetn(presetn),
				.trig_lines(trig_lines),
				.trigger_source_select(src_sel),
				.trigger_edge_polarity(edge_pol),
				.trig_pulse(trigger_pulse[g])
			);

			aacr_endian #(
				.WIDTH(DATA_W)
			) u_endian (
				.pclk(pclk),
				.presetn(presetn),
				.in_data(adc_data[DATA_W*g +: DATA_W]),
				.in_valid(adc_valid[g]),
				.swap(byte_order),
				.out_data(dma_data[DATA_W*g +: DATA_W]),
				.out_valid(dma_valid[g])
			);
		end
	endgenerate

	// read mux
	always @* begin
		next_rd = 32'h0000_0000;
		next_hit = hit_app_ctrl | hit_app_stat;
		if (hit_app_ctrl) begin
			next_rd[`AACR_LED_USER_HI:`AACR_LED_USER_LO] = user_led_pattern;
			next_rd[`AACR_LED_MODE_BIT] = led_mode_select;
			next_rd[`AACR_UNIT_EN_HI:`AACR_UNIT_EN_LO] = unit_en;
		end
		if (hit_app_stat) begin
			next_rd[`AACR_ERR_HI:`AACR_ERR_LO] = capture_unit_error;
		end
		for (i = 0; i < NUM_UNITS; i = i + 1) begin
			next_rd = next_rd | unit_rd[32*i +: 32];
			next_hit = next_hit | hit_dma[i] | hit_cap[i];
		end
	end

	// apb answer captured in setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rd;
			pslverr <= ~next_hit;
		end
	end
endmodule // aacr_top
`default_nettype wire

// file: aacr_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module aacr_monitor #(parameter ADDR_W = 12, parameter NUM_UNITS = 4) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// block side
	input wire logic [3:0] board_status_led,
	input wire logic [3:0] front_led,
	input wire logic [NUM_UNITS-1:0] capture_unit_enable,
	input wire logic [NUM_UNITS-1:0] capture_unit_error,
	input wire logic [NUM_UNITS-1:0] adc_valid,
	input wire logic [NUM_UNITS-1:0] dma_valid,
	input wire logic [NUM_UNITS-1:0] trigger_pulse
);
	// shadows of app control and unit 0 source
	logic [31:0] app;
	logic [3:0] src;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			app <= 32'h0000_0000;
			src <= 4'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == 12'h100)
				app <= pwdata;
			if (paddr == 12'h104)
				src <= pwdata[11:8];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_led_user_field: assert property (app[8] |=> front_led == $past(app[15:12]))
		else $error("user led mismatch");
	a_led_status_mode: assert property (!app[8] |=> front_led == $past(board_status_led))
		else $error("status led mismatch");
	a_unit_enable_bits: assert property (capture_unit_enable == app[NUM_UNITS-1:0])
		else $error("enable mismatch");
	a_error_clear_off: assert property (1'b1 |=> (capture_unit_error & ~$past(capture_unit_enable)) == 0)
		else $error("error not cleared");
	a_reserved_read_zero: assert property (psel && penable && !pwrite && paddr == 12'h100
		|-> (prdata & 32'hFFFF_0EF0) == 0)
		else $error("reserved bits set");
	a_data_path_latency: assert property (1'b1 |=> dma_valid == $past(adc_valid))
		else $error("dma valid latency");
	a_trig_single_pulse: assert property (1'b1 |=> (trigger_pulse & $past(trigger_pulse)) == 0)
		else $error("trigger pulse too long");
	a_trig_source_off: assert property ((src == 4'h0 || src > 4'hC) |=> !trigger_pulse[0])
		else $error("trigger while off");
endmodule // aacr_monitor
bind aacr_top aacr_monitor #(.ADDR_W(ADDR_W), .NUM_UNITS(NUM_UNITS)) aacr_monitor_i (.*);
`default_nettype wire

// file: tb_acquisition_app_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_acquisition_app_control_regs;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic [11:0] paddr, tl;
	logic [31:0] pwdata, prdata, r, v;
	logic [3:0] bsl, led, en, err, ev, tp, av, dv;
	logic [127:0] ad, dd;
	logic [3:0] dl;
	logic [127:0] dav, na;
	integer seed, miscompares, num_checks, i, p, n;
	aacr_top aacr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rear_trigger(tl[3:0]), .backplane_trigger(tl[11:4]), .trigger_pulse(tp), .board_status_led(bsl),
		.front_led(led), .capture_unit_enable(en), .capture_unit_error_event(ev), .capture_unit_error(err),
		.dma_addr_load(dl), .dma_addr_value(dav), .dma_next_write_address(na), .adc_data(ad),
		.adc_valid(av), .dma_data(dd), .dma_valid(dv));
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input [11:0] a, input [31:0] d);
		integer k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			conclude;
		end
		r = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tl, ev, av, ad, dl, dav} = 0;
		seed = 8;
		miscompares = 0;
		num_checks = 0;
		bsl = 4'h5;
		presetn = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		@(posedge pclk);
		chk(led, 4'h5);
		for (i = 0; i < 4; i++) begin
			apb(0, 12'h08C + 16 * i, 0);
			chk(r, 0);
			v = $random(seed);
			apb(1, 12'h08C + 16 * i, v);
			apb(0, 12'h08C + 16 * i, 0);
			chk(r, v);
			chk(na[32 * i +: 32], v);
			v = $random(seed);
			dav <= {4{v}};
			dl <= 4'h1 << i;
			@(posedge pclk);
			dl <= 4'h0;
			apb(0, 12'h08C + 16 * i, 0);
			chk(r, v);
			chk(na[32 * i +: 32], v);
			v = $random(seed);
			apb(1, 12'h104 + 16 * i, v);
			apb(0, 12'h104 + 16 * i, 0);
			chk(r, v & 32'h0001_FF00);
		end
		for (i = 0; i < 6; i++) begin
			v = $random(seed);
			bsl <= v[7:4];
			apb(1, 12'h100, 0);
			apb(1, 12'h100, v);
			apb(0, 12'h100, 0);
			chk(r, v & 32'h0000_F10F);
			chk(en, v[3:0]);
			chk(led, v[8] ? v[15:12] : v[7:4]);
		end
		apb(1, 12'h100, 0);
		apb(1, 12'h100, 1);
		for (i = 0; i < 16; i++)
			for (p = 0; p < 2; p++) begin
				apb(1, 12'h104, {p[3:0], i[3:0], 8'h00});
				repeat (6) @(posedge pclk);
				for (v = 0; v < 2; v++) begin
					tl <= v ? 12'h000 : (i >= 1 && i <= 12) ? 12'h001 << (i - 1) : 12'hFFF;
					n = 0;
					repeat (8) begin
						@(posedge pclk);
						n += tp[0];
					end
					chk(n, (i >= 1 && i <= 12 && p == v) ? 1 : 0);
				end
			end
		@(posedge pclk);
		ev <= 4'h1;
		@(posedge pclk);
		ev <= 4'h0;
		apb(0, 12'h160, 0);
		chk(r[12], 1'b1);
		chk(err, 4'h1);
		apb(1, 12'h100, 0);
		apb(0, 12'h160, 0);
		chk(r[15:12], 4'h0);
		chk(err, 4'h0);
		for (p = 0; p < 2; p++) begin
			apb(1, 12'h104, p << 16);
			apb(0, 12'h104, 0);
			chk(r, p << 16);
			v = $random(seed);
			ad <= {96'h0, v};
			av <= 4'h1;
			@(posedge pclk);
			av <= 4'h0;
			@(posedge pclk);
			chk(dd[31:0], p ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v);
			chk(dv, 4'h1);
		end
		apb(0, 12'h200, 0);
		chk(serr, 1'b1);
		conclude;
	end
endmodule // tb_acquisition_app_control_regs
`default_nettype wire
